// ===== bench/ots_terminal_reader.sv
// Model of external equipment that samples both output terminals
`timescale 1ns/1ps
module ots_terminal_reader (
  input wire logic aclk,
  input wire logic oc_terminal,
  input wire logic relay_terminal,
  output logic [1:0] seen
);
  // Equipment latches conducting and energised states every clock
  always_ff @(posedge aclk) begin
    seen <= {oc_terminal, relay_terminal};
  end
endmodule

// ===== bench/output_terminal_signal_selector_bench.sv
// Bench for the output terminal selector: bus tasks and terminal tests
`timescale 1ns/1ps
`include "ots_map.svh"
module output_terminal_signal_selector_bench;
  import ots_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, oc_terminal, relay_terminal;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, seen;
  logic [15:0] out_freq = 16'h0, cmd_freq = 16'h0, regen_duty = 16'h0;
  logic [15:0] regen_limit = 16'h0, thermal_acc = 16'h0, thermal_trip = 16'h0;
  logic [15:0] out_current = 16'h0, maint_hours = 16'h0, maint_limit = 16'hFFFF;
  logic [3:0] life_near_end = 4'h0;
  logic reverse_dir = 1'b0, dc_brake = 1'b0, drive_running = 1'b0;
  logic stall_active = 1'b0, init_done = 1'b0, start_ok = 1'b0, pid_below_low = 1'b0;
  logic pid_above_high = 1'b0, pid_forward = 1'b0, fan_failed = 1'b0;
  logic comm_warning = 1'b0, heatsink_near_hot = 1'b0, power_decel_start = 1'b0;
  logic power_decel_release = 1'b0, pid_running = 1'b0, pid_interrupted = 1'b0;
  logic retry_busy = 1'b0, hw_fault = 1'b0, cur_pulse = 1'b0;
  logic fault_trip = 1'b0, fault_reset = 1'b0;
  ots_code_t bad [4] = '{8'h50, 8'hB4, 8'hC8, 8'h02};
  int error_cnt = 0;
  int check_count = 0;
  // Clock of 40 ns period
  always #20 aclk = ~aclk;
  ots_selector #(.TICK_CYCLES(4)) u_dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
    .s_axi_wstrb(4'hF), .*);
  ots_terminal_reader u_far (.aclk(aclk), .oc_terminal(oc_terminal),
    .relay_terminal(relay_terminal), .seen(seen));
  // Compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  // Write with address and data offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(e));
  endtask
  // Read one word and check data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(e));
  endtask
  // Terminals as seen by the far side, after they settle
  task automatic t(input logic [1:0] e);
    repeat (4) @(posedge aclk);
    chk(32'(seen), 32'(e));
  endtask
  // Code on the open collector, then its inverted twin
  task automatic pair(input ots_code_t c, input logic f);
    wr(`OTS_ADDR_SEL_OC, {24'h0, c}, 2'h0);
    t({f, 1'b0});
    wr(`OTS_ADDR_SEL_OC, {24'h0, c + `OTS_INV_BASE}, 2'h0);
    t({~f, 1'b0});
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge aclk);
    error_cnt++;
    summarize;
  end
  // Test sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OTS_ADDR_SEL_OC, 32'h0, 2'h0);
    rd(`OTS_ADDR_SEL_RELAY, 32'h63, 2'h0);
    rd(8'h40, 32'h0, 2'h3);
    $display("test reset done");
    drive_running <= 1'b1;
    out_freq <= 16'h0032;
    pair(`OTS_CODE_RUN, 1'b1);
    out_freq <= 16'h0031;
    pair(`OTS_CODE_RUN, 1'b0);
    out_freq <= 16'h0258;
    cmd_freq <= 16'h0258;
    pair(`OTS_CODE_FTHR, 1'b1);
    pair(`OTS_CODE_SETPT, 1'b1);
    out_freq <= 16'h01F4;
    pair(`OTS_CODE_SETPT, 1'b0);
    dc_brake <= 1'b1;
    pair(`OTS_CODE_FTHR, 1'b0);
    dc_brake <= 1'b0;
    reverse_dir <= 1'b1;
    wr(`OTS_ADDR_FREQ_THR, 32'h0300_0258, 2'h0);
    pair(`OTS_CODE_FTHR, 1'b0);
    thermal_trip <= 16'h0064;
    thermal_acc <= 16'h0055;
    pair(`OTS_CODE_THERM, 1'b1);
    thermal_acc <= 16'h0054;
    pair(`OTS_CODE_THERM, 1'b0);
    $display("test analog flags done");
    stall_active <= 1'b1;
    pair(`OTS_CODE_STALL, 1'b1);
    hw_fault <= 1'b1;
    pair(`OTS_CODE_HW_FAULT, 1'b1);
    pid_forward <= 1'b1;
    pair(`OTS_CODE_PID_FWD, 1'b1);
    init_done <= 1'b1;
    pair(`OTS_CODE_READY, 1'b1);
    foreach (bad[i]) begin
      wr(`OTS_ADDR_SEL_OC, {24'h0, bad[i]}, 2'h0);
      t(2'b00);
    end
    wr(`OTS_ADDR_SEL_RELAY, 32'h5D, 2'h2);
    wr(`OTS_ADDR_SEL_RELAY, 32'hC1, 2'h2);
    rd(`OTS_ADDR_SEL_RELAY, 32'h63, 2'h0);
    cur_pulse <= 1'b1;
    pair(`OTS_CODE_CUR_PULSE, 1'b1);
    wr(`OTS_ADDR_SEL_OC, 32'h60, 2'h0);
    wr(`OTS_ADDR_REMOTE, 32'h1, 2'h0);
    t(2'b10);
    fault_trip <= 1'b1;
    @(posedge aclk);
    fault_trip <= 1'b0;
    t(2'b11);
    fault_reset <= 1'b1;
    @(posedge aclk);
    fault_reset <= 1'b0;
    t(2'b10);
    $display("test codes done");
    regen_limit <= 16'h0064;
    regen_duty <= 16'h0055;
    pair(`OTS_CODE_REGEN, 1'b1);
    pid_below_low <= 1'b1;
    pair(`OTS_CODE_PID_LO, 1'b1);
    pair(`OTS_CODE_PID_HI, 1'b0);
    comm_warning <= 1'b1;
    pair(`OTS_CODE_LIGHT, 1'b1);
    pair(`OTS_CODE_FAN, 1'b0);
    heatsink_near_hot <= 1'b1;
    pair(`OTS_CODE_HEATSINK, 1'b1);
    pid_running <= 1'b1;
    pair(`OTS_CODE_PID_ON, 1'b1);
    pair(`OTS_CODE_PID_SLEEP, 1'b0);
    retry_busy <= 1'b1;
    pair(`OTS_CODE_RETRY, 1'b1);
    life_near_end <= 4'h4;
    pair(`OTS_CODE_LIFE, 1'b1);
    maint_limit <= 16'h0010;
    maint_hours <= 16'h0010;
    pair(`OTS_CODE_MAINT, 1'b1);
    power_decel_start <= 1'b1;
    @(posedge aclk);
    power_decel_start <= 1'b0;
    pair(`OTS_CODE_PWR_DECEL, 1'b1);
    power_decel_release <= 1'b1;
    @(posedge aclk);
    power_decel_release <= 1'b0;
    pair(`OTS_CODE_PWR_DECEL, 1'b0);
    wr(`OTS_ADDR_CUR_LVL, 32'h0010_0100, 2'h0);
    wr(`OTS_ADDR_CUR_TIME, 32'h0002_0002, 2'h0);
    out_current <= 16'h0200;
    wr(`OTS_ADDR_SEL_OC, 32'h0C, 2'h0);
    t(2'b00);
    repeat (12) @(posedge aclk);
    t(2'b10);
    out_current <= 16'h0008;
    repeat (16) @(posedge aclk);
    pair(`OTS_CODE_UNDERCUR, 1'b1);
    $display("test status flags done");
    summarize;
  end
endmodule

// ===== hw/ots_selector.sv
// Output terminal signal selector with AXI4-Lite register access
//
// Function
// - Codes 0-99 drive the flag directly; 100-199 drive flag of code-100 inverted.
// - Code 0/100: motor running, output frequency at or above starting frequency.
// - Code 1/101: output frequency within sensitivity of commanded frequency.
// - Code 3/103: overload flag while stall prevention is active.
// - Code 4/104: frequency threshold, reverse threshold used in reverse.
// - Code 7/107: regenerative duty reached 85 percent of limit.
// - Code 8/108: thermal accumulator at 85 percent of trip level.
// - Code 11/111: ready after init, while start acceptable or running.
// - Code 12/112: current above threshold longer than detection time.
// - Code 13/113: current below low threshold longer than its time.
// - Codes 14, 15, 16: PID low, high and forward flags, inverted at +100.
// - Code 25 fan fault; code 98 light alarm on fan or comm warning.
// - Code 26/126: heatsink temperature near overheat level.
// - Code 46/146: power-failure deceleration, latched until released.
// - Code 47 PID control active; code 70 PID output interruption.
// - Code 64/164: retry processing in progress.
// - Code 90/190: any tracked part near end of life.
// - Code 91/191: fault from internal circuit failure or wiring error.
// - Code 93/193: averaged current pulse output; refused for the relay.
// - Code 95/195: maintenance timer at or above its alarm threshold.
// - Code 96/196: terminal follows the user remote output bit.
// - Code 99/199: fault latched from trip until fault reset.
// - Open-collector and relay terminals default to codes 0 and 99.
// - DC injection braking forces frequency related flags low.
`timescale 1ns/1ps
`include "ots_map.svh"
module ots_selector
  import ots_pkg::*;
#(
  parameter int TICK_CYCLES = `OTS_TICK_NS / `OTS_CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] cmd_freq,
  input wire logic reverse_dir,
  input wire logic dc_brake,
  input wire logic drive_running,
  input wire logic stall_active,
  input wire logic [15:0] regen_duty,
  input wire logic [15:0] regen_limit,
  input wire logic [15:0] thermal_acc,
  input wire logic [15:0] thermal_trip,
  input wire logic init_done,
  input wire logic start_ok,
  input wire logic [15:0] out_current,
  input wire logic pid_below_low,
  input wire logic pid_above_high,
  input wire logic pid_forward,
  input wire logic fan_failed,
  input wire logic comm_warning,
  input wire logic heatsink_near_hot,
  input wire logic power_decel_start,
  input wire logic power_decel_release,
  input wire logic pid_running,
  input wire logic pid_interrupted,
  input wire logic retry_busy,
  input wire logic [3:0] life_near_end,
  input wire logic hw_fault,
  input wire logic cur_pulse,
  input wire logic [15:0] maint_hours,
  input wire logic [15:0] maint_limit,
  input wire logic fault_trip,
  input wire logic fault_reset,
  output logic oc_terminal,
  output logic relay_terminal
);

  // Settings held by software
  ots_code_t sel_oc;
  ots_code_t sel_relay;
  logic [1:0] remote_out;
  ots_level_t start_freq;
  logic [6:0] sens_pct;
  ots_level_t fwd_thr;
  ots_level_t rev_thr;
  ots_level_t cur_hi;
  ots_level_t cur_lo;
  ots_level_t cur_hi_ms;
  ots_level_t cur_lo_ms;

  // Bus side state
  logic aw_got;
  logic w_got;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [1:0] next_bresp;

  // Status flag state
  ots_flags_t flags;
  logic pwr_decel_latch;
  logic fault_latch;
  logic [15:0] hi_count;
  logic [15:0] lo_count;
  logic [$clog2(TICK_CYCLES + 1) - 1:0] tick_div;
  logic ms_tick;
  logic cur_above;
  logic cur_below;
  ots_level_t thr_used;

  // True when val has reached pct percent of lim
  function automatic logic pct_reached(input logic [15:0] val, input logic [15:0] lim,
                                       input logic [23:0] pct);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(val) * `OTS_FULL_PCT;
    rhs = 24'(lim) * pct;
    return lhs >= rhs;
  endfunction

  // Checks a selection code against the listed set
  function automatic logic code_listed(input ots_code_t code);
    ots_code_t base;
    base = (code >= `OTS_INV_BASE) ? code - `OTS_INV_BASE : code;
    if (code >= `OTS_CODE_LIMIT) begin
      return 1'b0;
    end
    case (base)
      `OTS_CODE_RUN, `OTS_CODE_SETPT, `OTS_CODE_STALL, `OTS_CODE_FTHR,
      `OTS_CODE_REGEN, `OTS_CODE_THERM, `OTS_CODE_READY, `OTS_CODE_OVERCUR,
      `OTS_CODE_UNDERCUR, `OTS_CODE_PID_LO, `OTS_CODE_PID_HI, `OTS_CODE_PID_FWD,
      `OTS_CODE_FAN, `OTS_CODE_HEATSINK, `OTS_CODE_PWR_DECEL, `OTS_CODE_PID_ON,
      `OTS_CODE_RETRY, `OTS_CODE_PID_SLEEP, `OTS_CODE_LIFE, `OTS_CODE_HW_FAULT,
      `OTS_CODE_CUR_PULSE, `OTS_CODE_MAINT, `OTS_CODE_REMOTE, `OTS_CODE_LIGHT,
      `OTS_CODE_FAULT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Level that a selection code puts on a terminal
  function automatic logic term_level(input ots_code_t code, input ots_flags_t f,
                                      input logic remote_bit);
    ots_code_t base;
    logic inv;
    logic val;
    inv = (code >= `OTS_INV_BASE);
    base = inv ? code - `OTS_INV_BASE : code;
    case (base)
      `OTS_CODE_RUN: val = f.motor_running;
      `OTS_CODE_SETPT: val = f.at_setpoint_speed;
      `OTS_CODE_STALL: val = f.overload_stall_active;
      `OTS_CODE_FTHR: val = f.freq_threshold_reached;
      `OTS_CODE_REGEN: val = f.regen_brake_prealarm;
      `OTS_CODE_THERM: val = f.thermal_prealarm;
      `OTS_CODE_READY: val = f.ready_to_start;
      `OTS_CODE_OVERCUR: val = f.overcurrent_time_detect;
      `OTS_CODE_UNDERCUR: val = f.undercurrent_time_detect;
      `OTS_CODE_PID_LO: val = f.pid_low_limit;
      `OTS_CODE_PID_HI: val = f.pid_high_limit;
      `OTS_CODE_PID_FWD: val = f.pid_direction_forward;
      `OTS_CODE_FAN: val = f.fan_fault;
      `OTS_CODE_HEATSINK: val = f.heatsink_hot_prealarm;
      `OTS_CODE_PWR_DECEL: val = f.power_loss_decel;
      `OTS_CODE_PID_ON: val = f.pid_active;
      `OTS_CODE_RETRY: val = f.retry_in_progress;
      `OTS_CODE_PID_SLEEP: val = f.pid_sleep;
      `OTS_CODE_LIFE: val = f.end_of_life_alarm;
      `OTS_CODE_HW_FAULT: val = f.internal_fault_power_off;
      `OTS_CODE_CUR_PULSE: val = f.current_average_pulse;
      `OTS_CODE_MAINT: val = f.maintenance_hours_due;
      `OTS_CODE_REMOTE: val = remote_bit;
      `OTS_CODE_LIGHT: val = f.light_fault_warning;
      `OTS_CODE_FAULT: val = f.major_fault_output;
      default: val = 1'b0;
    endcase
    if (!code_listed(code)) begin
      return 1'b0;
    end
    return val ^ inv;
  endfunction

  // Threshold in use for the current direction
  assign thr_used = (reverse_dir && rev_thr != `OTS_REV_SAME) ? rev_thr : fwd_thr;
  assign cur_above = out_current > cur_hi;
  assign cur_below = out_current < cur_lo;

  // Flags derived from drive status
  always_comb begin
    logic [23:0] diff;
    diff = 24'h000000;
    flags = '0;
    diff = (out_freq >= cmd_freq) ? 24'(out_freq - cmd_freq) : 24'(cmd_freq - out_freq);
    flags.motor_running = drive_running && out_freq >= start_freq && !dc_brake;
    // Within band when the gap times 100 stays at or below sensitivity times command
    flags.at_setpoint_speed = !dc_brake && drive_running &&
        24'(cmd_freq) * 24'(sens_pct) >= diff * `OTS_FULL_PCT;
    flags.overload_stall_active = stall_active;
    flags.freq_threshold_reached = !dc_brake && out_freq >= thr_used;
    flags.regen_brake_prealarm = pct_reached(regen_duty, regen_limit, `OTS_PRE_PCT);
    flags.thermal_prealarm = pct_reached(thermal_acc, thermal_trip, `OTS_PRE_PCT);
    flags.ready_to_start = init_done && (start_ok || drive_running);
    flags.overcurrent_time_detect = hi_count > cur_hi_ms;
    flags.undercurrent_time_detect = lo_count > cur_lo_ms;
    flags.pid_low_limit = pid_below_low;
    flags.pid_high_limit = pid_above_high;
    flags.pid_direction_forward = pid_forward;
    flags.fan_fault = fan_failed;
    flags.heatsink_hot_prealarm = heatsink_near_hot;
    flags.power_loss_decel = pwr_decel_latch;
    flags.pid_active = pid_running;
    flags.retry_in_progress = retry_busy;
    flags.pid_sleep = pid_interrupted;
    flags.end_of_life_alarm = |life_near_end;
    flags.internal_fault_power_off = hw_fault;
    flags.current_average_pulse = cur_pulse;
    flags.maintenance_hours_due = maint_hours >= maint_limit;
    flags.light_fault_warning = fan_failed || comm_warning;
    flags.major_fault_output = fault_latch;
  end

  // Millisecond enable for the current detection timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div <= '0;
    end else if (ms_tick) begin
      tick_div <= '0;
    end else begin
      tick_div <= tick_div + 1'b1;
    end
  end
  assign ms_tick = (tick_div == ($bits(tick_div))'(TICK_CYCLES - 1));

  // High current duration, restarts when the current drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !cur_above) begin
      hi_count <= '0;
    end else if (ms_tick && hi_count != 16'hFFFF) begin
      hi_count <= hi_count + 16'h0001;
    end
  end

  // Low current duration, restarts when the current rises
  always_ff @(posedge aclk) begin
    if (!aresetn || !cur_below) begin
      lo_count <= '0;
    end else if (ms_tick && lo_count != 16'hFFFF) begin
      lo_count <= lo_count + 16'h0001;
    end
  end

  // Power-failure deceleration latch; the start wins over release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_decel_latch <= 1'b0;
    end else if (power_decel_start) begin
      pwr_decel_latch <= 1'b1;
    end else if (power_decel_release) begin
      pwr_decel_latch <= 1'b0;
    end
  end

  // Fault latch; a new trip wins over a reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_latch <= 1'b0;
    end else if (fault_trip) begin
      fault_latch <= 1'b1;
    end else if (fault_reset) begin
      fault_latch <= 1'b0;
    end
  end

  // Terminal drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_terminal <= 1'b0;
      relay_terminal <= 1'b0;
    end else begin
      oc_terminal <= term_level(sel_oc, flags, remote_out[0]);
      relay_terminal <= term_level(sel_relay, flags, remote_out[1]);
    end
  end

  // Write address and data are taken in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end
  end

  // Write response code for the pending write
  always_comb begin
    case (wr_addr)
      `OTS_ADDR_SEL_OC, `OTS_ADDR_REMOTE, `OTS_ADDR_FREQ_CFG, `OTS_ADDR_FREQ_THR,
      `OTS_ADDR_CUR_LVL, `OTS_ADDR_CUR_TIME: next_bresp = OTS_RESP_OKAY;
      `OTS_ADDR_SEL_RELAY: next_bresp = (wr_strb[0] &&
          wr_data[7:0] == `OTS_CODE_CUR_PULSE + `OTS_INV_BASE ||
          wr_strb[0] && wr_data[7:0] == `OTS_CODE_CUR_PULSE) ?
          OTS_RESP_SLVERR : OTS_RESP_OKAY;
      `OTS_ADDR_STATUS: next_bresp = OTS_RESP_SLVERR;
      default: next_bresp = OTS_RESP_DECERR;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OTS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Selection registers; a refused relay code leaves the old one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_oc <= `OTS_RST_SEL_OC;
      sel_relay <= `OTS_RST_SEL_RELAY;
      remote_out <= 2'h0;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_addr == `OTS_ADDR_SEL_OC) begin
        sel_oc <= wr_data[7:0];
      end
      if (wr_addr == `OTS_ADDR_SEL_RELAY && next_bresp == OTS_RESP_OKAY) begin
        sel_relay <= wr_data[7:0];
      end
      if (wr_addr == `OTS_ADDR_REMOTE) begin
        remote_out <= wr_data[1:0];
      end
    end
  end

  // Frequency and current settings, whole word writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_freq <= `OTS_RST_START_FREQ;
      sens_pct <= `OTS_RST_SENS_PCT;
      fwd_thr <= `OTS_RST_FWD_THR;
      rev_thr <= `OTS_REV_SAME;
      cur_hi <= `OTS_RST_CUR_HI;
      cur_lo <= `OTS_RST_CUR_LO;
      cur_hi_ms <= `OTS_RST_CUR_TIME;
      cur_lo_ms <= `OTS_RST_CUR_TIME;
    end else if (wr_fire && wr_strb == 4'hF) begin
      case (wr_addr)
        `OTS_ADDR_FREQ_CFG: begin
          start_freq <= wr_data[15:0];
          sens_pct <= wr_data[`OTS_SENS_POS +: 7];
        end
        `OTS_ADDR_FREQ_THR: begin
          fwd_thr <= wr_data[15:0];
          rev_thr <= wr_data[`OTS_REV_POS +: 16];
        end
        `OTS_ADDR_CUR_LVL: begin
          cur_hi <= wr_data[15:0];
          cur_lo <= wr_data[`OTS_LO_POS +: 16];
        end
        `OTS_ADDR_CUR_TIME: begin
          cur_hi_ms <= wr_data[15:0];
          cur_lo_ms <= wr_data[`OTS_LO_POS +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel, one read at a time
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= OTS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= OTS_RESP_OKAY;
      case (s_axi_araddr)
        `OTS_ADDR_SEL_OC: s_axi_rdata <= {24'h000000, sel_oc};
        `OTS_ADDR_SEL_RELAY: s_axi_rdata <= {24'h000000, sel_relay};
        `OTS_ADDR_REMOTE: s_axi_rdata <= {30'h0, remote_out};
        `OTS_ADDR_FREQ_CFG: s_axi_rdata <= {9'h0, sens_pct, start_freq};
        `OTS_ADDR_FREQ_THR: s_axi_rdata <= {rev_thr, fwd_thr};
        `OTS_ADDR_CUR_LVL: s_axi_rdata <= {cur_lo, cur_hi};
        `OTS_ADDR_CUR_TIME: s_axi_rdata <= {cur_lo_ms, cur_hi_ms};
        `OTS_ADDR_STATUS: s_axi_rdata <= {6'h00, flags, relay_terminal, oc_terminal};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= OTS_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // A write of the pulse code aimed at the relay selection
  sequence s_relay_pulse_write;
    wr_fire && wr_addr == `OTS_ADDR_SEL_RELAY && wr_strb[0] &&
        wr_data[7:0] == `OTS_CODE_CUR_PULSE;
  endsequence

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  inv_polarity_a: assert property ((sel_oc == `OTS_CODE_RUN + `OTS_INV_BASE) |=>
      oc_terminal == !$past(flags.motor_running)) else $error("inverted code not inverted");
  run_brake_a: assert property (dc_brake |-> !flags.motor_running &&
      !flags.at_setpoint_speed && !flags.freq_threshold_reached)
      else $error("frequency flag set under dc brake");
  run_level_a: assert property ((drive_running && !dc_brake &&
      out_freq >= start_freq && sel_oc == `OTS_CODE_RUN) |=> oc_terminal)
      else $error("running flag missing");
  rev_thr_a: assert property ((reverse_dir && rev_thr != `OTS_REV_SAME && !dc_brake &&
      out_freq >= rev_thr) |-> flags.freq_threshold_reached)
      else $error("reverse threshold ignored");
  relay_reject_a: assert property (s_relay_pulse_write |=>
      $stable(sel_relay) ##0 s_axi_bvalid && s_axi_bresp == OTS_RESP_SLVERR)
      else $error("pulse code accepted on relay");
  overcur_time_a: assert property ($rose(flags.overcurrent_time_detect) |->
      $past(cur_above) && hi_count > cur_hi_ms) else $error("overcurrent flag early");
  decel_hold_a: assert property ((pwr_decel_latch && !power_decel_release) |=>
      pwr_decel_latch) else $error("decel latch dropped");
  fault_hold_a: assert property ((fault_trip ##1 (!fault_reset)[*2]) |=>
      fault_latch) else $error("fault latch dropped");
  invalid_code_a: assert property ((sel_oc == 8'h50 || sel_oc == `OTS_CODE_LIMIT) |=>
      !oc_terminal) else $error("reserved code drives terminal");
  remote_a: assert property ((sel_relay == `OTS_CODE_REMOTE) |=>
      relay_terminal == $past(remote_out[1])) else $error("remote bit not followed");
  thermal_pre_a: assert property ((sel_oc == `OTS_CODE_THERM &&
      pct_reached(thermal_acc, thermal_trip, `OTS_PRE_PCT)) |=> oc_terminal)
      else $error("thermal prealarm missing");

endmodule

// ===== shared/ots_map.svh
// Register offsets, reset values, selection codes and timing counts
`ifndef OTS_MAP_SVH
`define OTS_MAP_SVH
`define OTS_ADDR_SEL_OC 8'h00
`define OTS_ADDR_SEL_RELAY 8'h04
`define OTS_ADDR_REMOTE 8'h08
`define OTS_ADDR_FREQ_CFG 8'h0C
`define OTS_ADDR_FREQ_THR 8'h10
`define OTS_ADDR_CUR_LVL 8'h14
`define OTS_ADDR_CUR_TIME 8'h18
`define OTS_ADDR_STATUS 8'h1C
`define OTS_RST_SEL_OC 8'h00
`define OTS_RST_SEL_RELAY 8'h63
`define OTS_RST_START_FREQ 16'h0032
`define OTS_RST_SENS_PCT 7'h0A
`define OTS_RST_FWD_THR 16'h0258
`define OTS_REV_SAME 16'hFFFF
`define OTS_RST_CUR_HI 16'hFFFF
`define OTS_RST_CUR_LO 16'h0000
`define OTS_RST_CUR_TIME 16'h0064
`define OTS_SENS_POS 16
`define OTS_REV_POS 16
`define OTS_LO_POS 16
`define OTS_INV_BASE 8'h64
`define OTS_CODE_LIMIT 8'hC8
`define OTS_PRE_PCT 24'h000055
`define OTS_FULL_PCT 24'h000064
`define OTS_CODE_RUN 8'h00
`define OTS_CODE_SETPT 8'h01
`define OTS_CODE_STALL 8'h03
`define OTS_CODE_FTHR 8'h04
`define OTS_CODE_REGEN 8'h07
`define OTS_CODE_THERM 8'h08
`define OTS_CODE_READY 8'h0B
`define OTS_CODE_OVERCUR 8'h0C
`define OTS_CODE_UNDERCUR 8'h0D
`define OTS_CODE_PID_LO 8'h0E
`define OTS_CODE_PID_HI 8'h0F
`define OTS_CODE_PID_FWD 8'h10
`define OTS_CODE_FAN 8'h19
`define OTS_CODE_HEATSINK 8'h1A
`define OTS_CODE_PWR_DECEL 8'h2E
`define OTS_CODE_PID_ON 8'h2F
`define OTS_CODE_RETRY 8'h40
`define OTS_CODE_PID_SLEEP 8'h46
`define OTS_CODE_LIFE 8'h5A
`define OTS_CODE_HW_FAULT 8'h5B
`define OTS_CODE_CUR_PULSE 8'h5D
`define OTS_CODE_MAINT 8'h5F
`define OTS_CODE_REMOTE 8'h60
`define OTS_CODE_LIGHT 8'h62
`define OTS_CODE_FAULT 8'h63
`define OTS_CLK_PERIOD_NS 40
`define OTS_TICK_NS 1000000
`endif

// ===== shared/ots_pkg.sv
// Types shared by the output terminal selector
package ots_pkg;
  typedef logic [7:0] ots_code_t;
  typedef logic [15:0] ots_level_t;
  typedef enum logic [1:0] {
    OTS_RESP_OKAY = 2'h0,
    OTS_RESP_SLVERR = 2'h2,
    OTS_RESP_DECERR = 2'h3
  } ots_resp_t;
  typedef struct packed {
    logic motor_running;
    logic at_setpoint_speed;
    logic overload_stall_active;
    logic freq_threshold_reached;
    logic regen_brake_prealarm;
    logic thermal_prealarm;
    logic ready_to_start;
    logic overcurrent_time_detect;
    logic undercurrent_time_detect;
    logic pid_low_limit;
    logic pid_high_limit;
    logic pid_direction_forward;
    logic fan_fault;
    logic heatsink_hot_prealarm;
    logic power_loss_decel;
    logic pid_active;
    logic retry_in_progress;
    logic pid_sleep;
    logic end_of_life_alarm;
    logic internal_fault_power_off;
    logic current_average_pulse;
    logic maintenance_hours_due;
    logic light_fault_warning;
    logic major_fault_output;
  } ots_flags_t;
endpackage
